// *** hw/pcp_pkg.sv ***
//==============================================================================
// Purpose : Shared constants and types for the core clock and PWM A block
// Assumes : 8-bit register port, one system clock at 10 MHz
// Notes   : Register offsets, field positions, reset values and counts
//==============================================================================
package pcp_pkg;

    //==========================================================================
    // Register offsets
    localparam logic [7:0] PLL_INPUT_CONFIG_OFF   = 8'h88;
    localparam logic [7:0] PLL_OUTPUT_DIVIDER_OFF = 8'h89;
    localparam logic [7:0] PWM_A_CONTROL_OFF      = 8'h8A;
    localparam logic [7:0] PWM_A_DUTY_OFF         = 8'h8B;
    localparam logic [7:0] PLL_STATUS_OFF         = 8'h8F;

    //==========================================================================
    // Reset values and writable-bit masks
    localparam logic [7:0] PLL_INPUT_CONFIG_RST   = 8'h07;
    localparam logic [7:0] PLL_OUTPUT_DIVIDER_RST = 8'h03;
    localparam logic [7:0] PWM_A_CONTROL_RST      = 8'h00;
    localparam logic [7:0] PWM_A_DUTY_RST         = 8'h00;
    localparam logic [7:0] PLL_INPUT_CONFIG_WMASK = 8'h9F;
    localparam logic [7:0] PLL_OUTPUT_DIV_WMASK   = 8'h07;
    localparam logic [7:0] PWM_A_CONTROL_WMASK    = 8'hDF;

    //==========================================================================
    // Field positions
    localparam int PLL_PREDIV_SEL_BIT   = 7;
    localparam int PLL_MULT_MSB         = 4;
    localparam int PLL_OUT_DIV_MSB      = 2;
    localparam int PWM_ENABLE_BIT       = 7;
    localparam int PWM_IDLE_LEVEL_BIT   = 6;
    localparam int PWM_FUNC_SEL_BIT     = 4;
    localparam int PWM_DIV_MSB          = 3;

    //==========================================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int PLL_LOCK_NS     = 100000;
    localparam int PLL_LOCK_CYCLES =
        (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_CNT_W      = 11;
    localparam int OSC_DIV_W       = 4;

    //==========================================================================
    // Types
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } pcp_bus_req_s;

    typedef enum logic [2:0] {
        OUT_IDLE  = 3'b001,
        OUT_RUN   = 3'b010,
        OUT_OSC16 = 3'b100
    } pcp_out_mode_e;

endpackage

// *** hw/pcp_pow2_acc.sv ***
//==============================================================================
// Purpose : Rate accumulator dividing an event count by a power of two
// Assumes : Shift never exceeds the accumulator width
// Notes   : Emits the whole number of output events each cycle
//==============================================================================
`timescale 1ns/1ps
module pcp_pow2_acc
#(
    parameter int INC_W = 6,
    parameter int SH_W  = 4,
    parameter int ACC_W = 8,
    parameter int SUM_W = 9
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             ce_i,
    // Rate control
    input  wire logic [INC_W-1:0] inc_i,
    input  wire logic [SH_W-1:0]  shift_i,
    // Output events this cycle
    output logic      [SUM_W-1:0] ticks_o
);

    logic [ACC_W-1:0] acc_q;
    logic [SUM_W-1:0] sum;
    logic [SUM_W-1:0] mask;

    //==========================================================================
    // Add input events, carry remainder below the divide point
    always_comb
    begin
        sum  = SUM_W'(acc_q) + SUM_W'(inc_i);
        mask = (SUM_W'(1) << shift_i) - SUM_W'(1);
    end

    // Remainder and whole quotient
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            acc_q   <= '0;
            ticks_o <= '0;
        end
        else if (ce_i)
        begin
            acc_q   <= ACC_W'(sum & mask);
            ticks_o <= sum >> shift_i;
        end
    end

endmodule

// *** hw/pcp_pll_pwm_a.sv ***
//==============================================================================
// Purpose : Core clock rate model and PWM channel A with register port
// Assumes : clk_i is the external oscillator; core clock is a tick count
// Notes   : Core rate above one per cycle shows as several ticks a cycle
//==============================================================================
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module pcp_pll_pwm_a
(
    // Clock, reset, enable
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 ce_i,
    // Register port
    input  wire pcp_pkg::pcp_bus_req_s bus_i,
    output logic      [7:0]           rdata_o,
    // Device state
    input  wire logic                 sleep_i,
    // Clock and PWM outputs
    output logic      [8:0]           core_ticks_o,
    output logic                      pll_locked_o,
    output logic                      pwm_a_output_o
);

    //==========================================================================
    // Declarations
    logic [7:0]                 pll_input_config_q;
    logic [7:0]                 pll_output_divider_q;
    logic [7:0]                 pwm_a_control_q;
    logic [7:0]                 pwm_a_duty_q;
    logic [pcp_pkg::LOCK_CNT_W-1:0] lock_cnt_q;
    logic [7:0]                 pwm_cnt_q;
    logic [pcp_pkg::OSC_DIV_W-1:0] osc_div_q;
    logic [15:0]                pwm_ticks;
    logic [5:0]                 mult_plus1;
    logic [3:0]                 core_shift;
    logic [3:0]                 pwm_shift;
    logic                       pll_prediv_sel;
    logic [4:0]                 pll_feedback_mult;
    logic [2:0]                 pll_out_div_code;
    logic                       pwm_enable;
    logic                       pwm_idle_level;
    logic                       pwm_func_sel;
    logic                       pll_write;
    pcp_pkg::pcp_out_mode_e     mode_d;

    //==========================================================================
    // Address match shared by write and read decode
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] off);
        hit = (addr == off);
    endfunction

    //==========================================================================
    // Field extraction
    assign pll_prediv_sel    = pll_input_config_q[pcp_pkg::PLL_PREDIV_SEL_BIT];
    assign pll_feedback_mult = pll_input_config_q[pcp_pkg::PLL_MULT_MSB:0];
    assign pll_out_div_code  = pll_output_divider_q[pcp_pkg::PLL_OUT_DIV_MSB:0];
    assign pwm_enable        = pwm_a_control_q[pcp_pkg::PWM_ENABLE_BIT];
    assign pwm_idle_level    = pwm_a_control_q[pcp_pkg::PWM_IDLE_LEVEL_BIT];
    assign pwm_func_sel      = pwm_a_control_q[pcp_pkg::PWM_FUNC_SEL_BIT];
    assign pwm_shift         = pwm_a_control_q[pcp_pkg::PWM_DIV_MSB:0];
    assign pll_write = ce_i && bus_i.we &&
                       (hit(bus_i.addr, pcp_pkg::PLL_INPUT_CONFIG_OFF) ||
                        hit(bus_i.addr, pcp_pkg::PLL_OUTPUT_DIVIDER_OFF));

    //==========================================================================
    // Configuration registers, reserved bits masked off
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pll_input_config_q   <= pcp_pkg::PLL_INPUT_CONFIG_RST;
            pll_output_divider_q <= pcp_pkg::PLL_OUTPUT_DIVIDER_RST;
            pwm_a_control_q      <= pcp_pkg::PWM_A_CONTROL_RST;
            pwm_a_duty_q         <= pcp_pkg::PWM_A_DUTY_RST;
        end
        else if (ce_i && bus_i.we)
        begin
            if (hit(bus_i.addr, pcp_pkg::PLL_INPUT_CONFIG_OFF))
            begin
                pll_input_config_q <= bus_i.wdata &
                    pcp_pkg::PLL_INPUT_CONFIG_WMASK;
            end
            else if (hit(bus_i.addr, pcp_pkg::PLL_OUTPUT_DIVIDER_OFF))
            begin
                pll_output_divider_q <= bus_i.wdata &
                    pcp_pkg::PLL_OUTPUT_DIV_WMASK;
            end
            else if (hit(bus_i.addr, pcp_pkg::PWM_A_CONTROL_OFF))
            begin
                pwm_a_control_q <= bus_i.wdata &
                    pcp_pkg::PWM_A_CONTROL_WMASK;
            end
            else if (hit(bus_i.addr, pcp_pkg::PWM_A_DUTY_OFF))
            begin
                pwm_a_duty_q <= bus_i.wdata;
            end
        end
    end

    //==========================================================================
    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (ce_i)
        begin
            if (!bus_i.re)
            begin
                rdata_o <= 8'h00;
            end
            else if (hit(bus_i.addr, pcp_pkg::PLL_INPUT_CONFIG_OFF))
            begin
                rdata_o <= pll_input_config_q;
            end
            else if (hit(bus_i.addr, pcp_pkg::PLL_OUTPUT_DIVIDER_OFF))
            begin
                rdata_o <= pll_output_divider_q;
            end
            else if (hit(bus_i.addr, pcp_pkg::PWM_A_CONTROL_OFF))
            begin
                rdata_o <= pwm_a_control_q;
            end
            else if (hit(bus_i.addr, pcp_pkg::PWM_A_DUTY_OFF))
            begin
                rdata_o <= pwm_a_duty_q;
            end
            else if (hit(bus_i.addr, pcp_pkg::PLL_STATUS_OFF))
            begin
                rdata_o <= {7'h00, pll_locked_o};
            end
            else
            begin
                rdata_o <= 8'h00; // Unmapped reads as zero
            end
        end
    end

    //==========================================================================
    // Lock timer restarted by any PLL write
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            lock_cnt_q   <= '0;
            pll_locked_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (pll_write)
            begin
                lock_cnt_q   <= '0;
                pll_locked_o <= 1'b0;
            end
            else if (lock_cnt_q !=
                     pcp_pkg::LOCK_CNT_W'(pcp_pkg::PLL_LOCK_CYCLES))
            begin
                lock_cnt_q <= lock_cnt_q + 1'b1;
            end
            else
            begin
                pll_locked_o <= 1'b1;
            end
        end
    end

    //==========================================================================
    // Core rate: times (N+1), over 2^(M+K) with M in {0,1}
    assign mult_plus1 = {1'b0, pll_feedback_mult} + 6'h01;
    assign core_shift = {3'h0, pll_prediv_sel} +
                        {1'h0, pll_out_div_code};

    pcp_pow2_acc
    #(
        .INC_W (6),
        .SH_W  (4),
        .ACC_W (8),
        .SUM_W (9)
    )
    u_core_rate
    (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .inc_i     (mult_plus1),
        .shift_i   (core_shift),
        .ticks_o   (core_ticks_o)
    );

    // PWM tick prescaler, core ticks over 2^code
    pcp_pow2_acc
    #(
        .INC_W (9),
        .SH_W  (4),
        .ACC_W (15),
        .SUM_W (16)
    )
    u_pwm_prescale
    (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .inc_i     (core_ticks_o),
        .shift_i   (pwm_shift),
        .ticks_o   (pwm_ticks)
    );

    //==========================================================================
    // Output mode; function select overrides enable and sleep
    always_comb
    begin
        if (pwm_func_sel)
        begin
            mode_d = pcp_pkg::OUT_OSC16;
        end
        else if (pwm_enable && !sleep_i)
        begin
            mode_d = pcp_pkg::OUT_RUN;
        end
        else
        begin
            mode_d = pcp_pkg::OUT_IDLE;
        end
    end

    //==========================================================================
    // Oscillator divide-by-sixteen phase
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            osc_div_q <= '0;
        end
        else if (ce_i)
        begin
            osc_div_q <= osc_div_q + 1'b1;
        end
    end

    // Duty counter, wraps every 256 ticks, cleared when stopped
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pwm_cnt_q <= 8'h00;
        end
        else if (ce_i)
        begin
            if (mode_d == pcp_pkg::OUT_RUN)
            begin
                pwm_cnt_q <= pwm_cnt_q + pwm_ticks[7:0];
            end
            else
            begin
                pwm_cnt_q <= 8'h00;
            end
        end
    end

    // Output pin flop
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pwm_a_output_o <= 1'b0;
        end
        else if (ce_i)
        begin
            case (mode_d)
                pcp_pkg::OUT_RUN:
                    pwm_a_output_o <= (pwm_cnt_q <= pwm_a_duty_q);
                pcp_pkg::OUT_OSC16:
                    pwm_a_output_o <= osc_div_q[pcp_pkg::OSC_DIV_W-1];
                default:
                    pwm_a_output_o <= pwm_idle_level;
            endcase
        end
    end

    //==========================================================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    logic pll_at_reset;
    assign pll_at_reset =
        (pll_input_config_q == pcp_pkg::PLL_INPUT_CONFIG_RST) &&
        (pll_output_divider_q == pcp_pkg::PLL_OUTPUT_DIVIDER_RST);

    default_rate_a: assert property (
        ce_i && pll_at_reset |=> core_ticks_o == 9'h001)
        else $error("Default PLL setting not one tick per cycle");

    mult_write_a: assert property (
        ce_i && bus_i.we &&
        bus_i.addr == pcp_pkg::PLL_INPUT_CONFIG_OFF
        |=> pll_input_config_q[6:5] == 2'h0 &&
            pll_feedback_mult == $past(bus_i.wdata[4:0]) &&
            pll_prediv_sel == $past(bus_i.wdata[7]))
        else $error("Input config write not stored with masking");

    no_div_rate_a: assert property (
        ce_i && core_shift == 4'h0 ##1 ce_i && core_shift == 4'h0
        |=> core_ticks_o == {3'h0, $past(mult_plus1)})
        else $error("Undivided core rate not N plus one");

    prediv_rate_a: assert property (
        ce_i && pll_prediv_sel && pll_out_div_code == 3'h0
        ##1 ce_i && $stable(pll_input_config_q) &&
        $stable(pll_output_divider_q)
        ##1 ce_i && $stable(pll_input_config_q) &&
        $stable(pll_output_divider_q)
        |=> core_ticks_o + $past(core_ticks_o) ==
            {3'h0, $past(mult_plus1, 2)} ||
            core_ticks_o + $past(core_ticks_o) ==
            {3'h0, $past(mult_plus1, 2)} + 9'h001)
        else $error("Pre-divider does not halve the rate");

    idle_level_a: assert property (
        ce_i && !pwm_func_sel && (!pwm_enable || sleep_i)
        |=> pwm_a_output_o == $past(pwm_idle_level))
        else $error("Idle output not at programmed level");

    osc_out_a: assert property (
        ce_i && pwm_func_sel && osc_div_q == 4'h7
        ##1 ce_i && pwm_func_sel
        |=> pwm_a_output_o && $past(!pwm_a_output_o))
        else $error("Oscillator over sixteen output misphased");

    full_duty_a: assert property (
        ce_i && mode_d == pcp_pkg::OUT_RUN && pwm_a_duty_q == 8'hFF
        |=> pwm_a_output_o)
        else $error("Full duty output went low");

    stop_clear_a: assert property (
        ce_i && mode_d != pcp_pkg::OUT_RUN |=> pwm_cnt_q == 8'h00)
        else $error("Duty counter not cleared when stopped");

    prescale_a: assert property (
        ce_i && pwm_shift == 4'h0 ##1 ce_i && pwm_shift == 4'h0
        |=> pwm_ticks == 16'($past(core_ticks_o)))
        else $error("Prescaler code zero does not pass ticks");

    reserved_read_a: assert property (
        ce_i && bus_i.re && bus_i.addr == pcp_pkg::PLL_OUTPUT_DIVIDER_OFF
        |=> rdata_o[7:3] == 5'h00)
        else $error("Reserved divider bits read nonzero");

    lock_clear_a: assert property (
        pll_write |=> !pll_locked_o)
        else $error("Lock status kept after PLL write");

    osc_mode_c: cover property (pwm_func_sel && $rose(pwm_a_output_o));
    pwm_run_c: cover property (mode_d == pcp_pkg::OUT_RUN &&
                               $fell(pwm_a_output_o));
    lock_done_c: cover property ($rose(pll_locked_o));

endmodule

// *** verif/pcp_pwm_load.sv ***
//==============================================================================
// Purpose : Load on the PWM A pin that counts high cycles and rising edges
// Assumes : Pin sampled on every rising edge of the system clock
// Notes   : Clear restarts both counts; passive, drives nothing back
//==============================================================================
`timescale 1ns/1ps
module pcp_pwm_load
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Window control
    input  wire logic        clear_i,
    // Observed pin
    input  wire logic        pwm_i,
    // Counts over the window
    output logic      [15:0] high_cnt_o,
    output logic      [15:0] rise_cnt_o
);
    logic last_q;

    //==========================================================================
    // Window counters
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            high_cnt_o <= 16'h0000;
            rise_cnt_o <= 16'h0000;
            last_q     <= 1'b0;
        end
        else if (clear_i)
        begin
            high_cnt_o <= 16'h0000;
            rise_cnt_o <= 16'h0000;
            last_q     <= pwm_i;
        end
        else
        begin
            high_cnt_o <= high_cnt_o + {15'h0000, pwm_i};
            rise_cnt_o <= rise_cnt_o + {15'h0000, pwm_i & ~last_q};
            last_q     <= pwm_i;
        end
    end
endmodule

// *** verif/pcp_pll_pwm_a_tb_top.sv ***
//==============================================================================
// Purpose : Self-checking bench for core clock rate and PWM channel A
// Assumes : 10 MHz clock; core rate seen as ticks per cycle
// Notes   : Expected counts derive from register settings only
//==============================================================================
`timescale 1ns/1ps
module pcp_pll_pwm_a_tb_top;
    logic                  clk_i;
    logic                  reset_n_i;
    logic                  ce_i;
    logic                  sleep_i;
    logic                  ld_clear;
    pcp_pkg::pcp_bus_req_s bus_i;
    logic [7:0]            rdata_o;
    logic [8:0]            core_ticks_o;
    logic                  pll_locked_o;
    logic                  pwm_a_output_o;
    logic [15:0]           ld_high;
    logic [15:0]           ld_rise;
    int                    n_errors;
    int                    checked;
    int                    t;

    //==========================================================================
    // Design and load
    pcp_pll_pwm_a dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .bus_i(bus_i), .rdata_o(rdata_o), .sleep_i(sleep_i),
        .core_ticks_o(core_ticks_o), .pll_locked_o(pll_locked_o),
        .pwm_a_output_o(pwm_a_output_o));
    pcp_pwm_load u_load (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .clear_i(ld_clear), .pwm_i(pwm_a_output_o),
        .high_cnt_o(ld_high), .rise_cnt_o(ld_rise));

    // Clock, 100 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    //==========================================================================
    // Shared tasks
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i.addr  <= a;
        bus_i.wdata <= d;
        bus_i.we    <= 1'b1;
        @(posedge clk_i);
        bus_i.we    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus_i.addr <= a;
        bus_i.re   <= 1'b1;
        @(posedge clk_i);
        bus_i.re   <= 1'b0;
        #1 check($sformatf("reg %0h", a), 32'(rdata_o), 32'(exp));
    endtask

    // Program both PLL registers, then wait out the lock time
    task automatic pll_set(input logic [7:0] c1, input logic [7:0] c2);
        int n;
        reg_wr(8'h88, c1);
        reg_wr(8'h89, c2);
        n = 0;
        while (pll_locked_o !== 1'b1 && n < 1200)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 1200)
        begin
            n_errors++;
            report_and_stop();
        end
        check("lock wait", 32'(n >= 990 && n <= 1010), 32'h1);
    endtask

    // Settle, then count core ticks and pin activity over a window
    task automatic measure(input int cyc, output int ticks);
        repeat (6) @(posedge clk_i);
        ld_clear <= 1'b1;
        @(posedge clk_i);
        ld_clear <= 1'b0;
        ticks = 0;
        repeat (cyc)
        begin
            @(posedge clk_i);
            #1 ticks += int'(core_ticks_o);
        end
    endtask

    //==========================================================================
    // Scenarios
    task automatic t_reset;
        rd_chk(8'h88, 8'h07);
        rd_chk(8'h89, 8'h03);
        rd_chk(8'h8A, 8'h00);
        measure(64, t);
        check("default rate", 32'(t), 32'd64);
        check("idle low", 32'(ld_high), 32'h0);
    endtask

    task automatic t_reserved;
        reg_wr(8'h88, 8'hFF);
        rd_chk(8'h88, 8'h9F);
        reg_wr(8'h89, 8'hFF);
        rd_chk(8'h89, 8'h07);
        rd_chk(8'h8F, 8'h00);
        reg_wr(8'h8A, 8'hFF);
        rd_chk(8'h8A, 8'hDF);
        reg_wr(8'h8A, 8'h00);
        rd_chk(8'h90, 8'h00);
        ce_i <= 1'b0;
        reg_wr(8'h8B, 8'h55);
        ce_i <= 1'b1;
        rd_chk(8'h8B, 8'h00);
    endtask

    // Every output divider code, then pre-divider and odd multiplier
    task automatic t_rate;
        for (int k = 0; k < 8; k++)
        begin
            pll_set(8'h1F, 8'(k));
            measure(256, t);
            check("rate k", 32'(t), 32'(8192 >> k));
        end
        pll_set(8'h9F, 8'h00);
        measure(256, t);
        check("rate prediv", 32'(t), 32'd4096);
        pll_set(8'h8B, 8'h03);
        measure(256, t);
        check("rate mixed", 32'(t), 32'd192);
        pll_set(8'h0F, 8'h04);
        rd_chk(8'h8F, 8'h01);
    endtask

    task automatic t_duty;
        logic [7:0] d [3] = '{8'h00, 8'h7F, 8'hFF};
        reg_wr(8'h8A, 8'h80);
        foreach (d[i])
        begin
            reg_wr(8'h8B, d[i]);
            measure(512, t);
            check("duty high", 32'(ld_high), 2 * (32'(d[i]) + 1));
            check("duty rise", 32'(ld_rise), d[i] == 8'hFF ? 0 : 2);
        end
        reg_wr(8'h8B, 8'h3F);
        reg_wr(8'h8A, 8'h81);
        measure(1024, t);
        check("div1 high", 32'(ld_high), 32'd256);
        check("div1 rise", 32'(ld_rise), 32'd2);
    endtask

    task automatic t_idle;
        reg_wr(8'h8A, 8'h80);
        sleep_i <= 1'b1;
        measure(64, t);
        check("sleep low", 32'(ld_high), 32'h0);
        reg_wr(8'h8A, 8'hC0);
        measure(64, t);
        check("sleep high", 32'(ld_high), 32'd64);
        sleep_i <= 1'b0;
        reg_wr(8'h8A, 8'h40);
        measure(64, t);
        check("off high", 32'(ld_high), 32'd64);
        reg_wr(8'h8A, 8'h00);
        measure(64, t);
        check("off low", 32'(ld_high), 32'h0);
    endtask

    task automatic t_osc16;
        reg_wr(8'h8A, 8'h50);
        measure(256, t);
        check("osc16 high", 32'(ld_high), 32'd128);
        check("osc16 rise", 32'(ld_rise), 32'd16);
        reg_wr(8'h8A, 8'hD0);
        sleep_i <= 1'b1;
        measure(256, t);
        check("osc16 sleep", 32'(ld_rise), 32'd16);
        sleep_i <= 1'b0;
    endtask

    // Fast core clock brought back to one tick per cycle by the divider
    task automatic t_div_fast;
        pll_set(8'h1F, 8'h00);
        reg_wr(8'h8B, 8'h7F);
        reg_wr(8'h8A, 8'h85);
        measure(512, t);
        check("div5 high", 32'(ld_high), 32'd256);
        check("div5 rise", 32'(ld_rise), 32'd2);
    endtask

    //==========================================================================
    // Main sequence
    initial
    begin
        bus_i     = '0;
        ce_i      = 1'b1;
        sleep_i   = 1'b0;
        ld_clear  = 1'b0;
        reset_n_i = 1'b0;
        n_errors  = 0;
        checked   = 0;
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_reserved();
        t_rate();
        t_duty();
        t_idle();
        t_osc16();
        t_div_fast();
        report_and_stop();
    end
endmodule
